/* src/pisc_device.sv */
`timescale 1ns/1ps
// Functional notes
// - Device is slave only, never drives clock.
// - Master makes start, address, phases, stop.
// - Address upper five bits are 10011.
// - Two straps give the two low bits.
// - Acknowledge only a matching address.
// - Write: address, inc plus index, data, acked.
// - Auto-increment advances index after each write.
// - Index wraps from 0x7F to 0x0.
// - Read follows an index write, repeated start.
// - Auto-increment advances index after each read.
// - Master acks wanted bytes, nacks last, stops.
// - Register 0 selects the page, 0 to 255.
module pisc_device
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Bus side.
    pisc_bus_if.device bus,
    // Address straps.
    input wire logic addr_strap_high,
    input wire logic addr_strap_low,
    // Register file side.
    output logic [7:0] page,
    output logic [6:0] index,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_ACK = 3'b011,
        S_REG = 3'b010,
        S_DATA = 3'b110,
        S_SEND = 3'b111,
        S_MACK = 3'b101
    } pisc_dev_state_t;

    pisc_dev_state_t state;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] shifter;
    logic [3:0] bit_count;
    logic reading;
    logic auto_inc;
    logic have_reg;
    logic ack_next;
    logic [7:0] mem [0:127];

    function automatic logic [6:0] pisc_next_index(input logic [6:0] cur);
        pisc_next_index = (cur == pisc_pkg::INDEX_LAST) ? pisc_pkg::INDEX_FIRST
                                                        : cur + 7'h01;
    endfunction

    pisc_edge_detect u_edges
    (
        .clock(clock),
        .rst_n(rst_n),
        .scl(bus.scl_i),
        .sda(bus.sda_i),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_seen(start_seen),
        .stop_seen(stop_seen)
    );

    // Only the data line is ever driven; the clock stays with the master.
    assign bus.sda_o = 1'b0;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= S_IDLE;
            shifter <= 8'h00;
            bit_count <= 4'h0;
            reading <= 1'b0;
            auto_inc <= 1'b0;
            have_reg <= 1'b0;
            ack_next <= 1'b0;
            bus.sda_oe <= 1'b0;
            index <= 7'h00;
            page <= pisc_pkg::PAGE_SELECT_RESET;
            reg_wr <= 1'b0;
            reg_wdata <= 8'h00;
        end
        else
        begin
            reg_wr <= 1'b0;
            if (start_seen)
            begin
                // A repeated start keeps the index loaded by the write phase.
                state <= S_ADDR;
                bit_count <= 4'h0;
                bus.sda_oe <= 1'b0;
            end
            else if (stop_seen)
            begin
                state <= S_IDLE;
                bus.sda_oe <= 1'b0;
            end
            else
            begin
                unique case (state)
                    S_IDLE:
                    begin
                        bus.sda_oe <= 1'b0;
                    end
                    S_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            shifter <= {shifter[6:0], bus.sda_i};
                            bit_count <= bit_count + 4'h1;
                        end
                        else if (scl_fall && bit_count == 4'h8)
                        begin
                            if (shifter[7:1] == {pisc_pkg::ADDR_PREFIX, addr_strap_high,
                                                 addr_strap_low})
                            begin
                                reading <= shifter[0];
                                have_reg <= 1'b0;
                                bus.sda_oe <= 1'b1;
                                state <= S_ACK;
                            end
                            else
                            begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_ACK:
                    begin
                        if (scl_fall)
                        begin
                            bit_count <= 4'h0;
                            if (reading)
                            begin
                                shifter <= mem[index];
                                bus.sda_oe <= ~mem[index][7];
                                state <= S_SEND;
                            end
                            else
                            begin
                                bus.sda_oe <= 1'b0;
                                state <= have_reg ? S_DATA : S_REG;
                            end
                        end
                    end
                    S_REG, S_DATA:
                    begin
                        if (scl_rise)
                        begin
                            shifter <= {shifter[6:0], bus.sda_i};
                            bit_count <= bit_count + 4'h1;
                        end
                        else if (scl_fall && bit_count == 4'h8)
                        begin
                            bus.sda_oe <= 1'b1;
                            have_reg <= 1'b1;
                            state <= S_ACK;
                            if (state == S_REG)
                            begin
                                auto_inc <= shifter[pisc_pkg::AUTO_INC_BIT];
                                index <= shifter[6:0];
                            end
                            else
                            begin
                                reg_wr <= 1'b1;
                                reg_wdata <= shifter;
                                if (index == pisc_pkg::PAGE_SELECT_OFFSET)
                                begin
                                    page <= shifter;
                                end
                                if (auto_inc)
                                begin
                                    index <= pisc_next_index(index);
                                end
                            end
                        end
                    end
                    S_SEND:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_count == 4'h7)
                            begin
                                bus.sda_oe <= 1'b0;
                                state <= S_MACK;
                                if (auto_inc)
                                begin
                                    index <= pisc_next_index(index);
                                end
                            end
                            else
                            begin
                                shifter <= {shifter[6:0], 1'b0};
                                bus.sda_oe <= ~shifter[6];
                                bit_count <= bit_count + 4'h1;
                            end
                        end
                    end
                    S_MACK:
                    begin
                        if (scl_rise)
                        begin
                            ack_next <= ~bus.sda_i;
                        end
                        else if (scl_fall)
                        begin
                            bit_count <= 4'h0;
                            if (ack_next)
                            begin
                                shifter <= mem[index];
                                bus.sda_oe <= ~mem[index][7];
                                state <= S_SEND;
                            end
                            else
                            begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    default:
                    begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // Register storage of the current page; location 0 mirrors the page select.
    always_ff @(posedge clock)
    begin
        if (state == S_DATA && scl_fall && bit_count == 4'h8 && !start_seen && !stop_seen)
        begin
            mem[index] <= shifter;
        end
        else if (state == S_IDLE)
        begin
            mem[pisc_pkg::PAGE_SELECT_OFFSET] <= page ^ reg_rdata ^ reg_rdata;
        end
    end
endmodule // pisc_device

/* inc/pisc_pkg.sv */
package pisc_pkg;
    // Upper five bits of the seven-bit slave address.
    localparam logic [4:0] ADDR_PREFIX = 5'h13;
    localparam logic [6:0] INDEX_LAST = 7'h7F;
    localparam logic [6:0] INDEX_FIRST = 7'h00;
    localparam logic [6:0] PAGE_SELECT_OFFSET = 7'h00;
    localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
    localparam int AUTO_INC_BIT = 7;
    // Host command port register offsets.
    localparam logic [3:0] HOST_CTRL = 4'h0;
    localparam logic [3:0] HOST_ADDR = 4'h1;
    localparam logic [3:0] HOST_WDATA = 4'h2;
    localparam logic [3:0] HOST_STATUS = 4'h3;
    localparam logic [3:0] HOST_RDATA = 4'h4;
    // Control register fields.
    localparam int CTRL_GO = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_INC = 2;
    // Status register fields.
    localparam int STAT_BUSY = 0;
    localparam int STAT_NACK = 1;
    // Bus timing: 20 MHz clock, fast-mode quarter bit of 625 ns.
    localparam int CLOCK_HZ = 20000000;
    localparam int QUARTER_NS = 625;
    localparam int QUARTER_CYCLES = (QUARTER_NS * (CLOCK_HZ / 1000000)) / 1000;
    localparam int DIV_W = 8;
endpackage

/* inc/pisc_bus_if.sv */
`timescale 1ns/1ps
interface pisc_bus_if;
    logic scl_o;
    logic scl_oe;
    logic sda_i;
    logic sda_o;
    logic sda_oe;
    logic scl_i;
    modport device (
        input scl_i,
        input sda_i,
        output sda_o,
        output sda_oe
    );
    modport host (
        input sda_i,
        input scl_i,
        output scl_o,
        output scl_oe,
        output sda_o,
        output sda_oe
    );
endinterface // pisc_bus_if

/* src/pisc_edge_detect.sv */
`timescale 1ns/1ps
module pisc_edge_detect
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Bus lines.
    input wire logic scl,
    input wire logic sda,
    // Detected events.
    output logic scl_rise,
    output logic scl_fall,
    output logic start_seen,
    output logic stop_seen
);
    logic scl_q;
    logic sda_q;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    assign scl_rise = scl & ~scl_q;
    assign scl_fall = ~scl & scl_q;
    assign start_seen = scl & scl_q & sda_q & ~sda;
    assign stop_seen = scl & scl_q & ~sda_q & sda;
endmodule // pisc_edge_detect

/* src/pisc_host.sv */
`timescale 1ns/1ps
module pisc_host
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Bus side.
    pisc_bus_if.host bus,
    // Command port.
    input wire logic [3:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    output logic [7:0] cmd_rdata
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_START = 3'b001,
        H_BYTE = 3'b011,
        H_ACK = 3'b010,
        H_STOP = 3'b110
    } pisc_host_state_t;

    pisc_host_state_t state;
    logic [7:0] dev_addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] shifter;
    logic [2:0] ctrl;
    logic busy;
    logic nack;
    logic [pisc_pkg::DIV_W-1:0] div;
    logic tick;
    logic [1:0] phase;
    logic [2:0] bit_no;
    logic [1:0] stage;
    logic rx;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div <= '0;
            tick <= 1'b0;
        end
        else
        begin
            // The compare sits one count early because tick is registered a cycle after the compare.
            tick <= (div == pisc_pkg::DIV_W'(pisc_pkg::QUARTER_CYCLES - 2));
            div <= tick ? '0 : div + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dev_addr <= 8'h00;
            wdata <= 8'h00;
            ctrl <= 3'h0;
            cmd_rdata <= 8'h00;
        end
        else
        begin
            ctrl[pisc_pkg::CTRL_GO] <= 1'b0;
            if (cmd_wr)
            begin
                unique case (cmd_addr)
                    pisc_pkg::HOST_CTRL: ctrl <= cmd_wdata[2:0];
                    pisc_pkg::HOST_ADDR: dev_addr <= cmd_wdata;
                    pisc_pkg::HOST_WDATA: wdata <= cmd_wdata;
                    default: ;
                endcase
            end
            if (cmd_rd)
            begin
                unique case (cmd_addr)
                    pisc_pkg::HOST_STATUS: cmd_rdata <= {6'h00, nack, busy};
                    pisc_pkg::HOST_RDATA: cmd_rdata <= rdata;
                    pisc_pkg::HOST_CTRL: cmd_rdata <= {5'h00, ctrl};
                    default: cmd_rdata <= 8'h00;
                endcase
            end
        end
    end

    // One command moves one frame: start, address byte, one data byte, stop.
    // The increment bit of the control word asks for a second data byte in the same frame.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= H_IDLE;
            busy <= 1'b0;
            nack <= 1'b0;
            rdata <= 8'h00;
            shifter <= 8'h00;
            phase <= 2'h0;
            bit_no <= 3'h0;
            stage <= 2'h0;
            rx <= 1'b0;
            bus.scl_oe <= 1'b0;
            bus.sda_oe <= 1'b0;
        end
        else if (state == H_IDLE)
        begin
            if (ctrl[pisc_pkg::CTRL_GO])
            begin
                busy <= 1'b1;
                nack <= 1'b0;
                state <= H_START;
                phase <= 2'h0;
            end
        end
        else if (tick)
        begin
            phase <= phase + 2'h1;
            unique case (state)
                H_START:
                begin
                    if (phase == 2'h1) bus.sda_oe <= 1'b1;
                    if (phase == 2'h3)
                    begin
                        bus.scl_oe <= 1'b1;
                        shifter <= dev_addr;
                        bit_no <= 3'h0;
                        stage <= 2'h0;
                        rx <= 1'b0;
                        state <= H_BYTE;
                    end
                end
                H_BYTE:
                begin
                    if (phase == 2'h0) bus.sda_oe <= rx ? 1'b0 : ~shifter[7];
                    if (phase == 2'h1) bus.scl_oe <= 1'b0;
                    if (phase == 2'h2 && rx) rdata <= {rdata[6:0], bus.sda_i};
                    if (phase == 2'h3)
                    begin
                        bus.scl_oe <= 1'b1;
                        shifter <= {shifter[6:0], 1'b0};
                        bit_no <= bit_no + 3'h1;
                        if (bit_no == 3'h7) state <= H_ACK;
                    end
                end
                H_ACK:
                begin
                    // A read byte is acknowledged only when another one follows.
                    if (phase == 2'h0)
                    begin
                        bus.sda_oe <= rx && ctrl[pisc_pkg::CTRL_INC] && (stage == 2'h1);
                    end
                    if (phase == 2'h1) bus.scl_oe <= 1'b0;
                    if (phase == 2'h2 && !rx && bus.sda_i) nack <= 1'b1;
                    if (phase == 2'h3)
                    begin
                        bus.scl_oe <= 1'b1;
                        stage <= stage + 2'h1;
                        bit_no <= 3'h0;
                        if (stage == 2'h2 || (stage == 2'h1 && !ctrl[pisc_pkg::CTRL_INC])
                            || (!rx && bus.sda_i))
                        begin
                            state <= H_STOP;
                        end
                        else
                        begin
                            rx <= ctrl[pisc_pkg::CTRL_READ];
                            shifter <= wdata;
                            state <= H_BYTE;
                        end
                    end
                end
                H_STOP:
                begin
                    if (phase == 2'h0) bus.sda_oe <= 1'b1;
                    if (phase == 2'h1) bus.scl_oe <= 1'b0;
                    if (phase == 2'h3)
                    begin
                        bus.sda_oe <= 1'b0;
                        busy <= 1'b0;
                        state <= H_IDLE;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    assign bus.scl_o = 1'b0;
    assign bus.sda_o = 1'b0;
endmodule // pisc_host

/* verif/pisc_properties.sv */
`timescale 1ns/1ps
module pisc_properties
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Bus lines.
    input wire logic scl_i,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic dev_sda_oe,
    // Register file side.
    input wire logic [7:0] page,
    input wire logic [6:0] index,
    input wire logic reg_wr
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    chk_released_after_reset: assert property (
        $rose(rst_n) |-> !scl_oe && !sda_oe && !dev_sda_oe)
        else $error("bus not released after reset");
    chk_dev_sda_scl_low: assert property (
        $changed(dev_sda_oe) |-> !scl_i)
        else $error("device moved data line while clock high");
    chk_ack_hold: assert property (
        $rose(dev_sda_oe) |-> dev_sda_oe [*8])
        else $error("device low drive too short");
    chk_no_contention: assert property (
        scl_i |-> !(sda_oe && dev_sda_oe))
        else $error("both ends drive data while clock high");
    chk_scl_high_min: assert property (
        $rose(scl_i) |-> scl_i [*8])
        else $error("clock high phase too short");
    chk_scl_low_min: assert property (
        $fell(scl_i) |-> !scl_i [*8])
        else $error("clock low phase too short");
    chk_wr_one_pulse: assert property (
        reg_wr |=> !reg_wr)
        else $error("register write strobe longer than one cycle");
    chk_page_by_write: assert property (
        $changed(page) |-> reg_wr || $past(reg_wr))
        else $error("page changed without a register write");
    chk_index_in_frame: assert property (
        $changed(index) |-> $past(scl_oe, 1) || $past(scl_oe, 2) || !scl_i)
        else $error("index changed while the bus was idle");
endmodule // pisc_properties

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic addr_strap_high = 1'b0;
    logic addr_strap_low = 1'b0;
    logic [3:0] cmd_addr = 4'h0;
    logic [7:0] cmd_wdata = 8'h00;
    logic cmd_wr = 1'b0;
    logic cmd_rd = 1'b0;
    logic [7:0] cmd_rdata;
    logic [7:0] page;
    logic [6:0] index;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic two_bytes = 1'b0;
    logic scl_w;
    logic sda_w;
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    logic [8:0] shift_reg = 9'h000;
    logic [8:0] first_nine = 9'h000;
    int bit_cnt = 0;
    int cycles = 0;
    int n_fail = 0;
    int samples_checked = 0;

    pisc_bus_if host_bus();
    pisc_bus_if dev_bus();

    // Open-drain wires: pulled up unless some end enables its low driver.
    assign scl_w = !host_bus.scl_oe;
    assign sda_w = !host_bus.sda_oe && !dev_bus.sda_oe;
    assign host_bus.scl_i = scl_w;
    assign host_bus.sda_i = sda_w;
    assign dev_bus.scl_i = scl_w;
    assign dev_bus.sda_i = sda_w;

    always #25 clock = ~clock;

    pisc_host pisc_host_inst (.clock(clock), .rst_n(rst_n), .bus(host_bus.host),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_rdata(cmd_rdata));
    pisc_device pisc_device_inst (.clock(clock), .rst_n(rst_n), .bus(dev_bus.device),
        .addr_strap_high(addr_strap_high), .addr_strap_low(addr_strap_low),
        .page(page), .index(index), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(8'h00));
    pisc_properties pisc_properties_inst (.clock(clock), .rst_n(rst_n),
        .scl_i(host_bus.scl_i), .scl_oe(host_bus.scl_oe), .sda_oe(host_bus.sda_oe),
        .dev_sda_oe(dev_bus.sda_oe), .page(page), .index(index), .reg_wr(reg_wr));

    // Keeps the first nine bits after each start: the address byte and its acknowledge.
    always @(posedge clock)
    begin
        scl_q <= scl_w;
        sda_q <= sda_w;
        if (scl_w && scl_q && sda_q && !sda_w)
            bit_cnt <= 0;
        else if (scl_w && !scl_q)
        begin
            shift_reg <= {shift_reg[7:0], sda_w};
            bit_cnt <= bit_cnt + 1;
            if (bit_cnt == 8)
                first_nine <= {shift_reg[7:0], sda_w};
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // About two dozen frames of at most fifteen hundred cycles each fit well below this.
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic cmd_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge clock);
        cmd_wr <= 1'b0;
    endtask

    task automatic cmd_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge clock);
        cmd_rd <= 1'b0;
        @(negedge clock);
        d = cmd_rdata;
    endtask

    // One host frame; returns the status once busy has dropped.
    task automatic frame(input logic [7:0] abyte, input logic [7:0] dbyte,
        output logic [7:0] st);
        int n;
        logic [7:0] ctrl;
        ctrl = 8'h00;
        ctrl[pisc_pkg::CTRL_GO] = 1'b1;
        ctrl[pisc_pkg::CTRL_READ] = abyte[0];
        ctrl[pisc_pkg::CTRL_INC] = two_bytes;
        cmd_write(pisc_pkg::HOST_ADDR, abyte);
        cmd_write(pisc_pkg::HOST_WDATA, dbyte);
        cmd_write(pisc_pkg::HOST_CTRL, ctrl);
        st = 8'hFF;
        for (n = 0; n < 3000 && st[pisc_pkg::STAT_BUSY] !== 1'b0; n++)
            cmd_read(pisc_pkg::HOST_STATUS, st);
    endtask

    task automatic frame_chk(input logic [7:0] abyte, input logic [7:0] dbyte,
        input logic nack);
        logic [7:0] st;
        frame(abyte, dbyte, st);
        check(16'(st[pisc_pkg::STAT_BUSY]), 16'h0000);
        check(16'(st[pisc_pkg::STAT_NACK]), 16'(nack));
        check(16'(first_nine), 16'({abyte, nack}));
    endtask

    task automatic set_straps(input logic [1:0] s);
        @(posedge clock);
        addr_strap_high <= s[1];
        addr_strap_low <= s[0];
    endtask

    task automatic test_reset();
        logic [7:0] d;
        check(16'(page), 16'(pisc_pkg::PAGE_SELECT_RESET));
        check(16'(index), 16'(pisc_pkg::INDEX_FIRST));
        cmd_read(4'hF, d);
        check(16'(d), 16'h0000);
    endtask

    task automatic test_straps();
        logic [1:0] s;
        for (int i = 0; i < 4; i++)
        begin
            s = 2'(i);
            set_straps(s);
            frame_chk({pisc_pkg::ADDR_PREFIX, s, 1'b0}, {1'b0, 5'h0A, s}, 1'b0);
            check(16'(index), 16'({5'h0A, s}));
            frame_chk({pisc_pkg::ADDR_PREFIX, s + 2'h1, 1'b0}, 8'h33, 1'b1);
            check(16'(index), 16'({5'h0A, s}));
        end
        frame_chk({5'h03, s, 1'b0}, 8'h33, 1'b1);
    endtask

    task automatic test_read_wrap();
        logic [7:0] d;
        set_straps(2'h0);
        two_bytes = 1'b1;
        frame_chk(8'h98, 8'hFF, 1'b0);
        check(16'(index), 16'(pisc_pkg::INDEX_FIRST));
        two_bytes = 1'b0;
        frame_chk(8'h98, 8'hFF, 1'b0);
        check(16'(index), 16'(pisc_pkg::INDEX_LAST));
        frame_chk(8'h99, 8'h00, 1'b0);
        check(16'(index), 16'(pisc_pkg::INDEX_FIRST));
        cmd_read(pisc_pkg::HOST_RDATA, d);
        check(16'(d), 16'h00FF);
        frame_chk(8'h99, 8'h00, 1'b0);
        cmd_read(pisc_pkg::HOST_RDATA, d);
        check(16'(d), 16'(pisc_pkg::PAGE_SELECT_RESET));
        check(16'(index), 16'h0001);
    endtask

    task automatic test_no_inc();
        logic [7:0] d;
        two_bytes = 1'b1;
        frame_chk(8'h98, 8'h10, 1'b0);
        check(16'(index), 16'h0010);
        two_bytes = 1'b0;
        frame_chk(8'h99, 8'h00, 1'b0);
        cmd_read(pisc_pkg::HOST_RDATA, d);
        check(16'(d), 16'h0010);
        check(16'(index), 16'h0010);
        frame_chk(8'h9B, 8'h00, 1'b1);
        check(16'(index), 16'h0010);
        frame_chk(8'h98, 8'h00, 1'b0);
        frame_chk(8'h99, 8'h00, 1'b0);
        cmd_read(pisc_pkg::HOST_RDATA, d);
        check(16'(d), 16'(pisc_pkg::PAGE_SELECT_RESET));
        check(16'(index), 16'h0000);
    endtask

    task automatic test_write_inc();
        logic [7:0] d;
        two_bytes = 1'b1;
        frame_chk(8'h98, 8'h80, 1'b0);
        check(16'(reg_wdata), 16'h0080);
        check(16'(page), 16'h0080);
        check(16'(index), 16'h0001);
        two_bytes = 1'b0;
        frame_chk(8'h98, 8'hFF, 1'b0);
        two_bytes = 1'b1;
        frame_chk(8'h99, 8'h00, 1'b0);
        cmd_read(pisc_pkg::HOST_RDATA, d);
        check(16'(d), 16'h0080);
        check(16'(index), 16'h0001);
        two_bytes = 1'b0;
    endtask

    initial
    begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        test_reset();
        test_straps();
        test_read_wrap();
        test_no_inc();
        test_write_inc();
        report_and_stop();
    end
endmodule // tb
